/* File: core/zero_turnaround_sram_sleep_ctrl.sv */
`timescale 1ns/100ps
// Behaviour
// - Sleep pin high forces sleep and deselect.
// - Sleep lasts exactly while pin stays high.
// - Asleep: inputs ignored, data outputs released.
// - Sampling stops within two clocks of rise.
// - Sampling resumes within two clocks of fall.
// - Burst order: low linear, high interleaved.
// - Selected only when all three selects agree.
// - Reads forward pending write data.
// - Clock hold high stalls, suppresses writes.
module zero_turnaround_sram_sleep_ctrl
   import sram_sleep_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              sleep_request,
   input  wire logic              cycle_hold_n,
   input  wire logic              chip_sel_n,
   input  wire logic              chip_sel2_n,
   input  wire logic              chip_sel_high,
   input  wire logic              burst_step_or_load,
   input  wire logic              read_not_write,
   input  wire logic              burst_order,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] data_in,
   output logic      [DATA_W-1:0] data_out,
   output logic                   data_oe,
   output logic                   asleep
);
   logic              sync1_r;
   logic              sync2_r;
   logic [ADDR_W-1:0] addr_r;
   logic [BURST_W-1:0] base_r;
   logic [BURST_W-1:0] cnt_r;
   logic              order_r;
   cyc_t              cyc_r;
   cyc_t              cyc_nxt;
   logic              wr_pend_r;
   logic [ADDR_W-1:0] wr_addr_r;
   logic              rd_pend_r;
   logic              fwd_r;
   logic [DATA_W-1:0] fwd_data_r;
   logic              selected;
   logic              sample;
   logic [ADDR_W-1:0] cur_addr;
   logic [BURST_W-1:0] step_lo;
   logic [ADDR_W-1:0] step_addr;
   // The pin is seen one edge late and asleep is a register: one extra edge.
   localparam int SLEEP_LIM = SLEEP_MAX_CYC + 1;

   sram_mem_if mem ();

   sram_array u_array (
      .sys_clk (sys_clk),
      .port    (mem.mem)
   );

   // The first stage is read only by the second.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= sleep_request;
         sync2_r <= sync1_r;
      end
   end

   assign selected = !chip_sel_n && !chip_sel2_n && chip_sel_high;
   assign sample   = !sync2_r && !cycle_hold_n;

   always_comb begin
      step_lo = '0;
      if (order_r) begin
         step_lo = base_r ^ (cnt_r + 2'h1);
      end else begin
         step_lo = base_r + cnt_r + 2'h1;
      end
      step_addr = {addr_r[ADDR_W-1:BURST_W], step_lo};
      cur_addr  = burst_step_or_load ? step_addr : addr;
   end

   always_comb begin
      cyc_nxt = ST_IDLE;
      if (!burst_step_or_load) begin
         if (selected) begin
            cyc_nxt = read_not_write ? ST_READ : ST_WRITE;
         end
      end else if (cyc_r != ST_IDLE) begin
         cyc_nxt = cyc_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cyc_r   <= ST_IDLE;
         addr_r  <= ADDR_RST;
         base_r  <= '0;
         cnt_r   <= '0;
         order_r <= 1'b0;
      end else if (sync2_r) begin
         cyc_r <= ST_IDLE;
      end else if (sample) begin
         cyc_r <= cyc_nxt;
         if (!burst_step_or_load) begin
            addr_r  <= addr;
            base_r  <= addr[BURST_W-1:0];
            cnt_r   <= '0;
            order_r <= burst_order;
         end else begin
            addr_r <= step_addr;
            cnt_r  <= cnt_r + 2'h1;
         end
      end
   end

   // Write data arrives one edge after its address; the array is written
   // at that same edge, so a read may find it still pending.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= ADDR_RST;
         rd_pend_r <= 1'b0;
         fwd_r     <= 1'b0;
         fwd_data_r <= DATA_RST;
      end else if (sync2_r) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         fwd_r     <= 1'b0;
      end else if (sample) begin
         wr_pend_r <= (cyc_nxt == ST_WRITE);
         wr_addr_r <= cur_addr;
         rd_pend_r <= (cyc_nxt == ST_READ);
         fwd_r      <= wr_pend_r && (wr_addr_r == cur_addr);
         fwd_data_r <= data_in;
      end else begin
         rd_pend_r <= 1'b0;
      end
   end

   always_comb begin
      mem.we    = wr_pend_r && sample;
      mem.waddr = wr_addr_r;
      mem.wdata = data_in;
      mem.raddr = cur_addr;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         data_out <= DATA_RST;
         data_oe  <= 1'b0;
         asleep   <= 1'b0;
      end else begin
         asleep <= sync2_r;
         if (sync2_r) begin
            data_oe <= 1'b0;
         end else begin
            data_oe <= rd_pend_r;
            data_out <= fwd_r ? fwd_data_r : mem.rdata;
         end
      end
   end

   property p_sleep_entry;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(sleep_request) |-> ##[1:SLEEP_LIM] asleep;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry)
      else $error("sleep not entered in time");

   property p_sleep_exit;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(sleep_request) |-> ##[1:SLEEP_LIM] !asleep;
   endproperty
   a_sleep_exit: assert property (p_sleep_exit)
      else $error("sleep not left in time");

   property p_sleep_hiz;
      @(posedge sys_clk) disable iff (!rst_n)
      asleep |-> !data_oe;
   endproperty
   a_sleep_hiz: assert property (p_sleep_hiz)
      else $error("output driven while asleep");

   property p_no_write_asleep;
      @(posedge sys_clk) disable iff (!rst_n)
      sync2_r |-> !mem.we;
   endproperty
   a_no_write_asleep: assert property (p_no_write_asleep)
      else $error("array written while asleep");

   property p_stall_no_write;
      @(posedge sys_clk) disable iff (!rst_n)
      cycle_hold_n |-> !mem.we;
   endproperty
   a_stall_no_write: assert property (p_stall_no_write)
      else $error("write during stall");

   property p_stall_holds;
      @(posedge sys_clk) disable iff (!rst_n)
      (cycle_hold_n && !sync2_r) |=> $stable(addr_r) && $stable(cyc_r);
   endproperty
   a_stall_holds: assert property (p_stall_holds)
      else $error("state moved during stall");

   property p_desel_idle;
      @(posedge sys_clk) disable iff (!rst_n)
      (sample && !burst_step_or_load && !selected) |=> cyc_r == ST_IDLE;
   endproperty
   a_desel_idle: assert property (p_desel_idle)
      else $error("cycle started while deselected");

   property p_sync_two;
      @(posedge sys_clk) disable iff (!rst_n)
      ##2 (sync2_r == $past(sleep_request, 2));
   endproperty
   a_sync_two: assert property (p_sync_two)
      else $error("synchroniser depth wrong");

   sequence s_read_load;
      sample && !burst_step_or_load && selected && read_not_write;
   endsequence
   property p_read_out;
      @(posedge sys_clk) disable iff (!rst_n)
      s_read_load ##1 !sync2_r |=> data_oe;
   endproperty
   a_read_out: assert property (p_read_out)
      else $error("read data not driven");
endmodule

/* File: inc/sram_sleep_pkg.sv */
package sram_sleep_pkg;
   localparam int ADDR_W      = 8;
   localparam int DATA_W      = 18;
   localparam int DEPTH       = 256;
   localparam int BURST_W     = 2;
   localparam int SYNC_STAGES = 2;
   // Longest allowed delay from sleep pin edge to sampling change, in ns.
   localparam int SLEEP_MAX_NS = 20;
   localparam int CLK_NS       = 10;
   localparam int SLEEP_MAX_CYC = SLEEP_MAX_NS / CLK_NS;
   localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
   localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} cyc_t;
endpackage

/* File: inc/sram_mem_if.sv */
`timescale 1ns/100ps
interface sram_mem_if;
   import sram_sleep_pkg::*;
   logic              we;
   logic [ADDR_W-1:0] waddr;
   logic [DATA_W-1:0] wdata;
   logic [ADDR_W-1:0] raddr;
   logic [DATA_W-1:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr,
                 input rdata);
   modport mem  (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface

/* File: core/sram_array.sv */
`timescale 1ns/100ps
module sram_array
   import sram_sleep_pkg::*;
(
   input wire logic sys_clk,
   sram_mem_if.mem  port
);
   logic [DATA_W-1:0] cells [DEPTH];

   always_ff @(posedge sys_clk) begin
      if (port.we) begin
         cells[port.waddr] <= port.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      port.rdata <= cells[port.raddr];
   end
endmodule

/* File: testbench/sram_host.sv */
`timescale 1ns/100ps
module sram_host
   import sram_sleep_pkg::*;
(
   input  wire logic              sys_clk,
   output logic                   cycle_hold_n,
   output logic                   chip_sel_n,
   output logic                   chip_sel2_n,
   output logic                   chip_sel_high,
   output logic                   burst_step_or_load,
   output logic                   read_not_write,
   output logic                   burst_order,
   output logic [ADDR_W-1:0]      addr,
   output logic [DATA_W-1:0]      data_in
);
   logic              wr_r = 1'b0;
   logic [DATA_W-1:0] wd_r = DATA_RST;
   initial begin
      {cycle_hold_n, chip_sel_n, chip_sel2_n, chip_sel_high} = 4'hE;
      {burst_step_or_load, read_not_write, burst_order} = 3'h1;
      addr = ADDR_RST;
      data_in = DATA_RST;
   end
   // Write data trails its address by one cycle; otherwise the bus toggles.
   task automatic op(input logic hold_n, input logic [2:0] sel,
                     input logic step, input logic rnw,
                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge sys_clk);
      data_in = wr_r ? wd_r : ~data_in;
      {chip_sel_n, chip_sel2_n, chip_sel_high} = sel;
      {cycle_hold_n, burst_step_or_load, read_not_write} = {hold_n, step, rnw};
      addr = a;
      wr_r = !rnw;
      wd_r = d;
   endtask
   task automatic set_order(input logic o);
      burst_order = o;
   endtask
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/100ps
module tb;
   import sram_sleep_pkg::*;
   typedef struct packed {
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d;
   } row_t;
   localparam row_t ROWS[5] = '{'{8'h00, 18'h3FFFF}, '{8'h01, 18'h00001},
      '{8'h02, 18'h2AAAA}, '{8'h03, 18'h15555}, '{8'hFF, 18'h0F0F0}};
   localparam logic [2:0] SEL = 3'b001;
   localparam logic [2:0] NOSEL[3] = '{3'b101, 3'b011, 3'b000};
   logic sys_clk, rst_n, sleep_request, hold_n, cs_n, cs2_n, cs_hi;
   logic ld, rnw, order, data_oe, asleep;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] data_in, data_out;
   logic [DATA_W:0]   e_nxt, e1, e2;
   logic [1:0]        b;
   int                failures, compares;
   always #5 sys_clk = ~sys_clk;
   sram_host i_host (.sys_clk(sys_clk), .cycle_hold_n(hold_n),
      .chip_sel_n(cs_n), .chip_sel2_n(cs2_n), .chip_sel_high(cs_hi),
      .burst_step_or_load(ld), .read_not_write(rnw), .burst_order(order),
      .addr(addr), .data_in(data_in));
   zero_turnaround_sram_sleep_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .sleep_request(sleep_request), .cycle_hold_n(hold_n),
      .chip_sel_n(cs_n), .chip_sel2_n(cs2_n), .chip_sel_high(cs_hi),
      .burst_step_or_load(ld), .read_not_write(rnw), .burst_order(order),
      .addr(addr), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .asleep(asleep));
   task automatic chk(input logic [DATA_W-1:0] seen,
                      input logic [DATA_W-1:0] want);
      compares++;
      if (seen !== want) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic end_sim;
      if (failures == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // One cycle on the bus; v and d give the read data due two edges later.
   task automatic bus(input logic h, input logic [2:0] s, input logic st,
                      input logic r, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic v);
      i_host.op(h, s, st, r, a, d);
      e_nxt = {v, d};
   endtask
   // Deselected read cycles: the address is loaded, but no cycle starts and nothing is driven.
   task automatic idle(input int n);
      repeat (n) bus(1'b0, 3'h0, 1'b0, 1'b1, 8'h00, DATA_RST, 1'b0);
   endtask
   always @(posedge sys_clk) begin
      e1 <= e_nxt;
      e2 <= e1;
   end
   always @(negedge sys_clk) begin
      if (rst_n) begin
         chk(data_oe, e2[DATA_W]);
         if (e2[DATA_W]) begin
            chk(data_out, e2[DATA_W-1:0]);
         end
      end
   end
   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      sleep_request = 1'b0;
      e_nxt = '0;
      failures = 0;
      compares = 0;
      repeat (6) @(negedge sys_clk);
      rst_n = 1'b1;
      chk(asleep, 1'b0);
      chk(data_oe, 1'b0);
      foreach (ROWS[i]) begin
         bus(1'b0, SEL, 1'b0, 1'b0, ROWS[i].a, ROWS[i].d, 1'b0);
         bus(1'b0, SEL, 1'b0, 1'b1, ROWS[i].a, ROWS[i].d, 1'b1);
      end
      for (int m = 0; m < 2; m++) begin
         i_host.set_order(m[0]);
         for (int k = 0; k < 4; k++) begin
            b = m[0] ? (2'h1 ^ k[1:0]) : (2'h1 + k[1:0]);
            bus(1'b0, SEL, k != 0, 1'b1, 8'h01, ROWS[b].d, 1'b1);
         end
      end
      foreach (NOSEL[i]) begin
         bus(1'b0, NOSEL[i], 1'b0, 1'b0, 8'h00, 18'h0ABCD, 1'b0);
      end
      bus(1'b1, SEL, 1'b0, 1'b0, 8'h00, 18'h0ABCD, 1'b0);
      idle(1);
      bus(1'b0, SEL, 1'b0, 1'b1, 8'h00, ROWS[0].d, 1'b1);
      idle(3);
      sleep_request = 1'b1;
      idle(2);
      bus(1'b0, SEL, 1'b0, 1'b0, 8'h00, 18'h11111, 1'b0);
      bus(1'b0, SEL, 1'b0, 1'b1, 8'h00, DATA_RST, 1'b0);
      chk(asleep, 1'b1);
      repeat (8) bus(1'b0, SEL, 1'b0, 1'b1, 8'h00, DATA_RST, 1'b0);
      chk(asleep, 1'b1);
      sleep_request = 1'b0;
      idle(2);
      bus(1'b0, SEL, 1'b0, 1'b1, 8'h00, ROWS[0].d, 1'b1);
      idle(3);
      chk(asleep, 1'b0);
      end_sim;
   end
endmodule
